//--- hw/rws_cfg.svh
// Constants of the receiver wake sequencer
`ifndef RWS_CFG_SVH
`define RWS_CFG_SVH
`define RWS_CLK_HZ          50000000
`define RWS_SAMPLE_HZ       615000
`define RWS_SAMPLE_DIV      (`RWS_CLK_HZ / `RWS_SAMPLE_HZ)
`define RWS_NOTICE_BAUD     310000
`define RWS_NOTICE_DIV      (`RWS_CLK_HZ / `RWS_NOTICE_BAUD)
`define RWS_TIMEOUT_STROBES 66
`define RWS_SLEEP_TICKS     2
`define RWS_RATIO_3         5'h03
`define RWS_RATIO_7         5'h07
`define RWS_RATIO_15        5'h0f
`define RWS_RATIO_31        5'h1f
`define RWS_MSN_TICKS       1
`endif

//--- hw/rws_pkg.sv
// Types of the receiver wake sequencer
package rws_pkg;
  typedef enum logic [9:0] {
    RWS_CONFIG    = 10'h001,
    RWS_S_SLEEP   = 10'h002,
    RWS_S_ID      = 10'h004,
    RWS_S_HDR     = 10'h008,
    RWS_S_DATA    = 10'h010,
    RWS_P_SLEEP   = 10'h020,
    RWS_P_ID      = 10'h040,
    RWS_P_NOTICE  = 10'h080,
    RWS_P_HDR     = 10'h100,
    RWS_P_DATA    = 10'h200
  } rws_state_t;

  typedef struct packed {
    logic       strobe_osc_enable;
    logic [1:0] sleep_run_ratio;
    logic [7:0] id_word;
  } rws_cfg_t;

  typedef struct packed {
    logic id_match;
    logic id_inv_match;
    logic hdr_match;
    logic hdr_inv_match;
    logic eom;
    logic data_bit;
    logic data_valid;
  } rws_rx_t;

  typedef struct packed {
    logic sdata;
    logic sclk;
    logic drive;
  } rws_ser_t;
endpackage : rws_pkg

//--- hw/rws_shifter.sv
// Byte shifter driving data and clock at a set bit period
`timescale 1ns/1ps
module rws_shifter #(
  parameter int DIV_W = 8
) (
  input  wire logic             ref_clk_in,
  input  wire logic             rst_in,
  input  wire logic             load_in,
  input  wire logic [7:0]       byte_in,
  input  wire logic [DIV_W-1:0] half_div_in,
  output logic                  busy_out,
  output logic                  sdata_out,
  output logic                  sclk_out
);
  logic [7:0]       sh_r;
  logic [3:0]       cnt_r;
  logic [DIV_W-1:0] div_r;

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      sh_r      <= 8'h00;
      cnt_r     <= 4'h0;
      div_r     <= '0;
      busy_out  <= 1'b0;
      sdata_out <= 1'b0;
      sclk_out  <= 1'b0;
    end else if (load_in && !busy_out) begin
      sh_r      <= {byte_in[6:0], 1'b0};
      sdata_out <= byte_in[7];
      cnt_r     <= 4'h0;
      div_r     <= '0;
      busy_out  <= 1'b1;
      sclk_out  <= 1'b0;
    end else if (busy_out) begin
      if (div_r == half_div_in) begin
        div_r    <= '0;
        sclk_out <= !sclk_out;
        if (sclk_out) begin
          // Falling edge advances to the next bit
          if (cnt_r == 4'h7) begin
            busy_out <= 1'b0;
          end else begin
            cnt_r     <= cnt_r + 4'h1;
            sdata_out <= sh_r[7];
            sh_r      <= {sh_r[6:0], 1'b0};
          end
        end
      end else begin
        div_r <= div_r + {{(DIV_W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule : rws_shifter

//--- hw/rws_sequencer.sv
// Run-state sequencer of the receiver wake logic
`timescale 1ns/1ps
`include "rws_cfg.svh"
module rws_sequencer
  import rws_pkg::*;
#(
  parameter int TIMEOUT_STROBES = `RWS_TIMEOUT_STROBES
) (
  input  wire logic              ref_clk_in,
  input  wire logic              rst_in,
  input  wire logic              mode_select_n_in,
  input  wire logic              wake_control_pin_in,
  input  wire logic              wake_pin_at_supply_in,
  input  wire logic              strobe_tick_in,
  input  wire rws_pkg::rws_cfg_t cfg_in,
  input  wire rws_pkg::rws_rx_t  rx_in,
  output rws_pkg::rws_ser_t      ser_out,
  output logic                   rx_power_out,
  output logic                   strobe_osc_on_out,
  output logic                   discharge_en_out,
  output logic                   config_mode_out,
  output logic [9:0]             state_out
);
  import rws_pkg::*;

  localparam int SDIV = `RWS_SAMPLE_DIV;
  localparam int NDIV = `RWS_NOTICE_DIV / 2;

  rws_state_t state_r, state_nxt;
  logic [7:0] sdiv_r;
  logic       tick;
  logic [1:0] msn_cnt_r;
  logic       invert_r;
  logic       eom_r;
  logic [4:0] strobe_cnt_r;
  logic [6:0] tmo_cnt_r;
  logic [1:0] sleep_cnt_r;
  logic       go_sleep_r;
  logic [7:0] ser_byte_r;
  logic [2:0] bit_cnt_r;
  logic       load;
  logic       busy;
  logic       sh_data;
  logic       sh_clk;
  logic [4:0] ratio;
  logic [7:0] half_div;
  logic       id_hit;
  logic       hdr_hit;
  logic       pin_hi;
  logic       byte_rdy_r;
  logic       notice_r;
  logic       sleep_go;

  // Sample tick derived from the system clock
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || sdiv_r == 8'(SDIV - 1)) begin
      sdiv_r <= 8'h00;
    end else begin
      sdiv_r <= sdiv_r + 8'h01;
    end
  end
  assign tick = (sdiv_r == 8'(SDIV - 1));

  always_comb begin
    case (cfg_in.sleep_run_ratio)
      2'h0:    ratio = `RWS_RATIO_3;
      2'h1:    ratio = `RWS_RATIO_7;
      2'h2:    ratio = `RWS_RATIO_15;
      default: ratio = `RWS_RATIO_31;
    endcase
  end

  // Pin tied to supply acts as a permanently raised wake pin
  assign pin_hi  = wake_control_pin_in || wake_pin_at_supply_in;
  // Match flags come from a comparator fed by the Manchester-coded ID word
  assign id_hit  = rx_in.id_match || rx_in.id_inv_match;
  assign hdr_hit = rx_in.hdr_match || rx_in.hdr_inv_match;

  // Mode select filter: low for more than one sample tick
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || mode_select_n_in) begin
      msn_cnt_r <= 2'h0;
    end else if (tick && msn_cnt_r != 2'h3) begin
      msn_cnt_r <= msn_cnt_r + 2'h1;
    end
  end

  // Strobe counter runs in sleep to time the next wake
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || state_r != RWS_S_SLEEP) begin
      strobe_cnt_r <= 5'h00;
    end else if (strobe_tick_in && strobe_cnt_r != ratio) begin
      strobe_cnt_r <= strobe_cnt_r + 5'h01;
    end
  end

  // Header wait timeout counter in strobe periods
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || state_r != RWS_S_HDR) begin
      tmo_cnt_r <= 7'h00;
    end else if (strobe_tick_in && tmo_cnt_r != 7'(TIMEOUT_STROBES)) begin
      tmo_cnt_r <= tmo_cnt_r + 7'h01;
    end
  end

  // Polarity latched from which header form arrived
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      invert_r <= 1'b0;
    end else if ((state_r == RWS_S_HDR || state_r == RWS_P_HDR) && hdr_hit) begin
      invert_r <= rx_in.hdr_inv_match;
    end
  end

  // End of message seen during pin-controlled data output
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || state_r != RWS_P_DATA) begin
      eom_r <= 1'b0;
    end else if (rx_in.eom) begin
      eom_r <= 1'b1;
    end
  end

  // Pending sleep entry: finish the byte, then wait two sample ticks
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      go_sleep_r  <= 1'b0;
      sleep_cnt_r <= 2'h0;
    end else if (!go_sleep_r) begin
      sleep_cnt_r <= 2'h0;
      if ((state_r == RWS_S_DATA && rx_in.eom) ||
          (state_r == RWS_S_HDR &&
           tmo_cnt_r == 7'(TIMEOUT_STROBES)) ||
          (state_r == RWS_S_ID && strobe_tick_in && !id_hit) ||
          ((state_r == RWS_P_ID || state_r == RWS_P_NOTICE ||
            state_r == RWS_P_HDR || state_r == RWS_P_DATA) &&
           !pin_hi)) begin
        go_sleep_r <= 1'b1;
      end
    end else if (sleep_go) begin
      // Cleared on arrival, else the next telegram stays frozen
      go_sleep_r  <= 1'b0;
      sleep_cnt_r <= 2'h0;
    end else if (!busy && !load && tick) begin
      sleep_cnt_r <= sleep_cnt_r + 2'h1;
    end
  end

  // Sleep entry on the second idle tick once the shifter is free
  assign sleep_go = go_sleep_r && !busy && !load && tick &&
                    sleep_cnt_r == 2'(`RWS_SLEEP_TICKS - 1);

  // Byte assembly of received data for the shifter
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      ser_byte_r <= 8'h00;
      bit_cnt_r  <= 3'h0;
      byte_rdy_r <= 1'b0;
    end else if (state_r == RWS_P_ID && id_hit && tick) begin
      ser_byte_r <= cfg_in.id_word;
      bit_cnt_r  <= 3'h0;
      byte_rdy_r <= 1'b0;
    end else if (state_r == RWS_S_HDR || state_r == RWS_P_HDR) begin
      // Each telegram starts on a byte boundary with nothing pending
      bit_cnt_r  <= 3'h0;
      byte_rdy_r <= 1'b0;
    end else if (rx_in.data_valid && !go_sleep_r &&
                 (state_r == RWS_S_DATA || state_r == RWS_P_DATA)) begin
      ser_byte_r <= {ser_byte_r[6:0], rx_in.data_bit ^ invert_r};
      bit_cnt_r  <= bit_cnt_r + 3'h1;
      byte_rdy_r <= bit_cnt_r == 3'h7;
    end else if (load) begin
      byte_rdy_r <= 1'b0;
    end
  end

  // A byte goes out once all eight bits are in, zero bytes included
  assign load = (state_r == RWS_P_NOTICE && !busy && tick) ||
                ((state_r == RWS_S_DATA || state_r == RWS_P_DATA) &&
                 !eom_r && byte_rdy_r && !busy);

  // Notice rate kept for the whole notice byte, not only its first cycle
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      notice_r <= 1'b0;
    end else if (load) begin
      notice_r <= state_r == RWS_P_NOTICE;
    end
  end

  assign half_div = (state_r == RWS_P_NOTICE || notice_r) ?
                    8'(NDIV - 1) : 8'(SDIV - 1);

  rws_shifter #(
    .DIV_W (8)
  ) u_shifter (
    .ref_clk_in  (ref_clk_in),
    .rst_in      (rst_in),
    .load_in     (load),
    .byte_in     (ser_byte_r),
    .half_div_in (half_div),
    .busy_out    (busy),
    .sdata_out   (sh_data),
    .sclk_out    (sh_clk)
  );

  // Next state; a pending sleep entry freezes every other move
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      RWS_CONFIG: begin
        if (mode_select_n_in) begin
          state_nxt = cfg_in.strobe_osc_enable ? RWS_S_SLEEP : RWS_P_SLEEP;
        end
      end
      RWS_S_SLEEP: begin
        if (!cfg_in.strobe_osc_enable) state_nxt = RWS_P_SLEEP;
        else if (strobe_cnt_r == ratio || pin_hi) state_nxt = RWS_S_ID;
      end
      RWS_S_ID:    if (id_hit) state_nxt = RWS_S_HDR;
      RWS_S_HDR:   if (hdr_hit) state_nxt = RWS_S_DATA;
      RWS_S_DATA:  state_nxt = RWS_S_DATA;
      RWS_P_SLEEP: begin
        if (cfg_in.strobe_osc_enable) state_nxt = RWS_S_SLEEP;
        else if (pin_hi) state_nxt = RWS_P_ID;
      end
      RWS_P_ID:     if (id_hit) state_nxt = RWS_P_NOTICE;
      RWS_P_NOTICE: if (busy) state_nxt = RWS_P_HDR;
      RWS_P_HDR:    if (hdr_hit) state_nxt = RWS_P_DATA;
      RWS_P_DATA:   state_nxt = RWS_P_DATA;
      default:      state_nxt = RWS_CONFIG;
    endcase
    if (go_sleep_r) begin
      state_nxt = state_r;
      if (sleep_go) begin
        state_nxt = cfg_in.strobe_osc_enable ? RWS_S_SLEEP : RWS_P_SLEEP;
      end
    end
  end

  // State register: sample-tick paced except the notice exit on busy, mode select overrides
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      state_r <= RWS_CONFIG;
    end else if (msn_cnt_r > 2'(`RWS_MSN_TICKS)) begin
      state_r <= RWS_CONFIG;
    end else if (tick || (state_r == RWS_P_NOTICE && busy)) begin
      state_r <= state_nxt;
    end
  end

  // Output registers
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      ser_out           <= '0;
      rx_power_out      <= 1'b1;
      strobe_osc_on_out <= 1'b1;
      discharge_en_out  <= 1'b1;
      config_mode_out   <= 1'b1;
      state_out         <= 10'h001;
    end else begin
      ser_out.drive     <= state_r != RWS_CONFIG;
      // Raw pass-through after end of message carries no clock
      if (state_r == RWS_P_DATA && eom_r) begin
        ser_out.sdata <= rx_in.data_bit;
        ser_out.sclk  <= 1'b0;
      end else begin
        ser_out.sdata <= sh_data;
        ser_out.sclk  <= sh_clk && state_r != RWS_P_NOTICE;
      end
      rx_power_out      <= !(state_r == RWS_S_SLEEP ||
                             state_r == RWS_P_SLEEP);
      strobe_osc_on_out <= cfg_in.strobe_osc_enable;
      discharge_en_out  <= !wake_pin_at_supply_in;
      config_mode_out   <= state_r == RWS_CONFIG;
      state_out         <= state_r;
    end
  end
endmodule : rws_sequencer

//--- dv/rws_host_model.sv
// Host model: holds the wake pin and collects serial bytes
`timescale 1ns/1ps
module rws_host_model
  import rws_pkg::*;
(
  input  wire logic              ref_clk_in,
  input  wire logic              want_in,
  input  wire rws_pkg::rws_ser_t ser_in,
  output logic                   wake_out,
  output logic [7:0]             byte_out,
  output int                     count_out
);
  logic [7:0] sh_r  = 8'h00;
  logic [2:0] n_r   = 3'h0;
  logic       clk_r = 1'b0;
  initial byte_out  = 8'h00;
  initial count_out = 0;
  // Pin stays high for as long as the telegram is wanted
  assign wake_out = want_in;
  // Bytes arrive MSB first, taken on a rising serial clock
  always @(posedge ref_clk_in) begin
    clk_r <= ser_in.sclk;
    if (ser_in.drive && ser_in.sclk && !clk_r) begin
      sh_r <= {sh_r[6:0], ser_in.sdata};
      n_r  <= n_r + 3'h1;
      if (n_r == 3'h7) begin
        byte_out  <= {sh_r[6:0], ser_in.sdata};
        count_out <= count_out + 1;
      end
    end
  end
endmodule : rws_host_model

//--- dv/rws_sequencer_asserts.sv
// Checker of the receiver wake sequencer
`timescale 1ns/1ps
module rws_sequencer_chk
  import rws_pkg::*;
#(
  parameter int TIMEOUT_STROBES = 66
) (
  input wire logic              ref_clk_in,
  input wire logic              rst_in,
  input wire logic              mode_select_n_in,
  input wire logic              wake_control_pin_in,
  input wire logic              wake_pin_at_supply_in,
  input wire logic              strobe_tick_in,
  input wire rws_pkg::rws_cfg_t cfg_in,
  input wire rws_pkg::rws_rx_t  rx_in,
  input wire rws_pkg::rws_ser_t ser_out,
  input wire logic              rx_power_out,
  input wire logic              strobe_osc_on_out,
  input wire logic              discharge_en_out,
  input wire logic              config_mode_out,
  input wire logic [9:0]        state_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  int msn_c = 0;
  int wk_c  = 0;
  int to_c  = 0;
  always_ff @(posedge ref_clk_in) begin
    msn_c <= (rst_in || mode_select_n_in) ? 0 : msn_c + 1;
  end
  always_ff @(posedge ref_clk_in) begin
    wk_c <= ((state_out == RWS_P_SLEEP || state_out == RWS_S_SLEEP) &&
             wake_control_pin_in && mode_select_n_in) ? wk_c + 1 : 0;
  end
  always_ff @(posedge ref_clk_in) begin
    to_c <= (state_out != RWS_S_HDR) ? 0 : to_c + int'(strobe_tick_in);
  end
  property p_msn; msn_c > 330 |-> state_out == RWS_CONFIG; endproperty
  a_msn: assert property (p_msn) else $error("config not forced");
  property p_psleep;
    state_out == RWS_P_SLEEP [*2] |-> !rx_power_out;
  endproperty
  a_psleep: assert property (p_psleep) else $error("rx on in sleep");
  property p_ssleep;
    state_out == RWS_S_SLEEP [*2] |-> strobe_osc_on_out && !rx_power_out;
  endproperty
  a_ssleep: assert property (p_ssleep) else $error("bad sleep");
  property p_sup; wake_pin_at_supply_in [*3] |-> !discharge_en_out;
  endproperty
  a_sup: assert property (p_sup) else $error("discharge on");
  property p_wake; wk_c < 250; endproperty
  a_wake: assert property (p_wake) else $error("no wake");
  property p_tmo; to_c <= TIMEOUT_STROBES + 2; endproperty
  a_tmo: assert property (p_tmo) else $error("no timeout");
  property p_drop;
    (state_out == RWS_P_ID || state_out == RWS_P_HDR) &&
      !wake_control_pin_in && !wake_pin_at_supply_in
      |-> ##[1:250] state_out inside {RWS_P_SLEEP, RWS_CONFIG};
  endproperty
  a_drop: assert property (p_drop) else $error("no sleep");
  property p_sid;
    state_out == RWS_S_ID |=> state_out inside
      {RWS_S_ID, RWS_S_HDR, RWS_S_SLEEP, RWS_CONFIG};
  endproperty
  a_sid: assert property (p_sid) else $error("bad step");
  c_pdata: cover property (state_out == RWS_P_DATA);
  c_sdata: cover property (state_out == RWS_S_DATA);
  c_tmo: cover property (state_out == RWS_S_HDR ##1 state_out != RWS_S_HDR);
endmodule : rws_sequencer_chk
bind rws_sequencer rws_sequencer_chk #(
  .TIMEOUT_STROBES(TIMEOUT_STROBES)
) i_chk (.*);

//--- dv/rws_sequencer_tb.sv
// Testbench of the receiver wake sequencer
`timescale 1ns/1ps
module rws_sequencer_tb;
  import rws_pkg::*;
  logic       ref_clk_in = 1'b0;
  logic       rst_in = 1'b1;
  logic       msn = 1'b1;
  logic       want = 1'b0;
  logic       sup = 1'b0;
  logic       stb = 1'b0;
  logic       wake;
  rws_cfg_t   cfg = '0;
  rws_rx_t    rx = '0;
  rws_ser_t   ser;
  logic       rxp, osc, dis, cfgm;
  logic [9:0] st;
  logic [7:0] hb;
  int         hn;
  int n_fail = 0;
  int total_checks = 0;
  int cyc = 0;
  int sc = 0;
  int nst = 0;
  bit stb_on = 1'b0;
  always #10 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    sc <= (sc == 299) ? 0 : sc + 1;
    stb <= #1 stb_on && sc == 299;
    if (stb_on && sc == 299) nst <= nst + 1;
    if (cyc == 95000) begin
      n_fail++;
      end_of_test();
    end
  end
  rws_sequencer #(.TIMEOUT_STROBES(3)) i_dut (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .mode_select_n_in(msn),
    .wake_control_pin_in(wake), .wake_pin_at_supply_in(sup),
    .strobe_tick_in(stb), .cfg_in(cfg), .rx_in(rx), .ser_out(ser),
    .rx_power_out(rxp), .strobe_osc_on_out(osc),
    .discharge_en_out(dis), .config_mode_out(cfgm), .state_out(st));
  rws_host_model i_host (.ref_clk_in(ref_clk_in), .want_in(want),
    .ser_in(ser), .wake_out(wake), .byte_out(hb), .count_out(hn));
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic tk(int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask : tk
  task automatic wait_st(rws_state_t s, int lim);
    for (int i = 0; i < lim && st !== s; i++) tk(1);
  endtask : wait_st
  task automatic t_pin();
    logic [7:0] d;
    d = 8'h3c;
    cfg = '{1'b0, 2'h0, 8'hb4};
    wait_st(RWS_P_SLEEP, 400);
    tk(400);
    check("pin sleep", st, RWS_P_SLEEP);
    check("rx power", rxp, 1'b0);
    check("osc off", osc, 1'b0);
    want = 1'b1;
    wait_st(RWS_P_ID, 200);
    tk(400);
    check("id search", st, RWS_P_ID);
    rx.id_inv_match = 1'b1;
    wait_st(RWS_P_NOTICE, 200);
    rx.id_inv_match = 1'b0;
    wait_st(RWS_P_HDR, 4000);
    tk(1400);
    check("notice byte", hb, 8'hb4);
    check("notice count", hn, 1);
    check("hdr search", st, RWS_P_HDR);
    rx.hdr_inv_match = 1'b1;
    wait_st(RWS_P_DATA, 200);
    rx.hdr_inv_match = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      rx.data_bit = d[i];
      rx.data_valid = 1'b1;
      tk(1);
      rx.data_valid = 1'b0;
      tk(199);
    end
    tk(3000);
    check("inverted byte", hb, 8'hc3);
    check("byte count", hn, 2);
    rx.eom = 1'b1;
    tk(1);
    rx.eom = 1'b0;
    rx.data_bit = 1'b1;
    tk(2);
    check("raw one", ser.sdata, 1'b1);
    rx.data_bit = 1'b0;
    tk(2);
    check("raw zero", ser.sdata, 1'b0);
    check("raw no clock", ser.sclk, 1'b0);
    want = 1'b0;
    wait_st(RWS_P_SLEEP, 3000);
    check("pin drop", st, RWS_P_SLEEP);
    want = 1'b1;
    wait_st(RWS_P_ID, 200);
    want = 1'b0;
    wait_st(RWS_P_SLEEP, 400);
    check("id drop", st, RWS_P_SLEEP);
    $display("done pin wake");
  endtask : t_pin
  task automatic t_strobe();
    int n;
    for (int r = 0; r < 4; r++) begin
      cfg = '{1'b1, r[1:0], 8'hb4};
      stb_on = 1'b1;
      wait_st(RWS_S_ID, 12000);
      wait_st(RWS_S_SLEEP, 2000);
      wait_st(RWS_S_ID, 12000);
      n = nst;
      wait_st(RWS_S_SLEEP, 2000);
      wait_st(RWS_S_ID, 12000);
      check("ratio", nst - n, 4 << r);
    end
    rx.id_match = 1'b1;
    wait_st(RWS_S_HDR, 400);
    rx.id_match = 1'b0;
    n = nst;
    wait_st(RWS_S_SLEEP, 3000);
    check("timeout", nst - n >= 2 && nst - n <= 4, 1'b1);
    wait_st(RWS_S_ID, 12000);
    rx.id_match = 1'b1;
    wait_st(RWS_S_HDR, 400);
    rx.id_match = 1'b0;
    rx.hdr_match = 1'b1;
    wait_st(RWS_S_DATA, 400);
    rx.hdr_match = 1'b0;
    check("data state", st, RWS_S_DATA);
    rx.eom = 1'b1;
    wait_st(RWS_S_SLEEP, 3000);
    rx.eom = 1'b0;
    check("eom sleep", st, RWS_S_SLEEP);
    check("sleep rx off", rxp, 1'b0);
    check("osc on", osc, 1'b1);
    $display("done strobe wake");
  endtask : t_strobe
  task automatic t_pins();
    msn = 1'b0;
    tk(1);
    msn = 1'b1;
    tk(200);
    check("short low", cfgm, 1'b0);
    msn = 1'b0;
    tk(340);
    check("config", st, RWS_CONFIG);
    msn = 1'b1;
    sup = 1'b1;
    tk(5);
    check("discharge", dis, 1'b0);
    sup = 1'b0;
    $display("done pins");
  endtask : t_pins
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  initial begin
    tk(10);
    rst_in = 1'b0;
    check("reset", st, RWS_CONFIG);
    t_pin();
    t_strobe();
    t_pins();
    end_of_test();
  end
endmodule : rws_sequencer_tb
